// [hw/mwk_consts.svh]
// register indices, field positions, reset values and timing counts
`ifndef MWK_CONSTS_SVH
`define MWK_CONSTS_SVH

// register indices; the byte address on the bus is four times the index
`define MWK_IDX_DCLICK      8'h5B
`define MWK_IDX_WAKE_CTL    8'h5C
`define MWK_IDX_IRQ_STATUS  8'h15
`define MWK_IDX_IRQ_MASK    8'h5E

// double_click_interval fields
`define MWK_DCLICK_SPIN_BIT 7
`define MWK_DCLICK_RSVD_BIT 6
`define MWK_DCLICK_IVL_HI   5
`define MWK_DCLICK_IVL_LO   0
`define MWK_DCLICK_RESET    8'h0C

// mouse_wake_control fields
`define MWK_CTL_LOCK_BIT    7
`define MWK_CTL_SWAP_BIT    6
`define MWK_CTL_SEL_HI      4
`define MWK_CTL_SEL_LO      2
`define MWK_CTL_RESET       8'h00

// interrupt status and mask layout
`define MWK_IRQ_FLAG_BIT    4
`define MWK_IRQ_RESET       8'h00

// timing: figures in ns and the cycle counts derived from them
`define MWK_CLK_PERIOD_NS   10
`define MWK_DCLICK_UNIT_NS  85937500
`define MWK_SPINUP_NS       2000000000
`define MWK_DCLICK_UNIT_CYCLES (`MWK_DCLICK_UNIT_NS / `MWK_CLK_PERIOD_NS)
`define MWK_SPINUP_CYCLES   (`MWK_SPINUP_NS / `MWK_CLK_PERIOD_NS)

// counter widths
`define MWK_TICK_W          24
`define MWK_SPIN_W          28
`define MWK_WIN_W           7

`endif

// [hw/mwk_pkg.sv]
// types shared by the mouse wake control block
`default_nettype none
package mwk_pkg;
	// wake event select encodings
	typedef enum logic [2:0] {
		MWK_SEL_ANY_ACT  = 3'h0,
		MWK_SEL_LEFT     = 3'h1,
		MWK_SEL_RIGHT    = 3'h2,
		MWK_SEL_ANY_CLK  = 3'h3,
		MWK_SEL_RSVD4    = 3'h4,
		MWK_SEL_DBL_LEFT = 3'h5,
		MWK_SEL_DBL_RGHT = 3'h6,
		MWK_SEL_RSVD7    = 3'h7
	} mwk_sel_t;

	// bus slave phase
	typedef enum logic {
		MWK_BUS_IDLE,
		MWK_BUS_WAIT
	} mwk_bus_t;
endpackage
`default_nettype wire

// [hw/mwk_timer.sv]
// loadable down counter, busy while nonzero
`default_nettype none
module mwk_timer #(
	parameter int unsigned W = 8
) (
	// clock and control
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic         ce,
	// load and count
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	input  wire logic         step,
	// state
	output logic              busy
);
	logic [W-1:0] count;  // remaining steps

	// load wins over counting so a restart is never lost
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else if (ce) begin
			if (load) begin
				count <= load_val;
			end else if (step && count != '0) begin
				count <= count - W'(1);
			end
		end
	end

	assign busy = (count != '0);
endmodule // mwk_timer
`default_nettype wire

// [hw/mwk_tick.sv]
// restartable prescaler giving one pulse every period cycles
`default_nettype none
module mwk_tick #(
	parameter int unsigned W      = 24,
	parameter int unsigned PERIOD = 4
) (
	// clock and control
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic restart,
	// tick
	output logic      tick
);
	logic [W-1:0] div;  // cycles since last tick

	wire  last = (div == W'(PERIOD - 1));  // end of a period

	// restart realigns phase so a window lasts whole periods
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			div <= '0;
		end else if (ce) begin
			if (restart || last) begin
				div <= '0;
			end else begin
				div <= div + W'(1);
			end
		end
	end

	assign tick = last & ~restart;
endmodule // mwk_tick
`default_nettype wire

// [hw/mwk_mouse_wake.sv]
// mouse wake control: registers, event recognition, wake and interrupt
//
// Notes on behaviour
// - interval bounds gap between double clicks
// - interval is (code+1) steps of 0.0859375 s
// - interval bit 6 always reads zero
// - interval bit 7 one skips spin-up delay
// - lock set makes both registers ignore writes
// - every reset kind clears the lock
// - select codes 0-3 pick single events
// - codes 5,6 double left/right; 4,7 none
// - recognised event drives the wake output
// - control bit 5 always reads zero
// - control bit 6 swaps keyboard and mouse
// - event sets sticky flag, write one clears
//
// Register access over AHB-Lite was left to the implementer.
`default_nettype none
`include "mwk_consts.svh"
module mwk_mouse_wake
	import mwk_pkg::*;
#(
	parameter int unsigned SPINUP_CYCLES      = `MWK_SPINUP_CYCLES,
	parameter int unsigned DCLICK_UNIT_CYCLES = `MWK_DCLICK_UNIT_CYCLES
) (
	// clock, battery power-on reset, clock enable
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// secondary resets, synchronous levels
	input  wire logic        standby_supply_power_on_reset,
	input  wire logic        main_supply_power_on_reset,
	input  wire logic        bus_reset,
	// decoded mouse packets
	input  wire logic        mouse_pkt_valid,
	input  wire logic        mouse_left,
	input  wire logic        mouse_right,
	input  wire logic        mouse_middle,
	input  wire logic        mouse_moved,
	// results
	output logic             port_swap,
	output logic             pme_wake,
	output logic             irq,
	output logic             spinup_busy
);
	// does a word address hit a register index
	function automatic logic reg_hit(input logic [7:0] idx,
			input logic [7:0] want);
		reg_hit = (idx == want);
	endfunction

	// bus slave state
	mwk_bus_t    bus_st;     // idle or one wait state
	logic        pend_wr;    // latched write flag
	logic        pend_ok;    // latched address is an aligned word inside the 1 KB window
	logic [7:0]  pend_idx;   // latched register index

	// register contents
	logic        spin_off;   // interval bit 7
	logic [5:0]  ivl_code;   // interval steps minus one
	logic        lock;       // control bit 7
	logic        swap;       // control bit 6
	logic [2:0]  sel_code;   // control bits 4:2
	logic        wake_click_flag;  // sticky status bit
	logic        flag_mask;  // mask for the status bit

	// mouse state
	logic [2:0]  prev_btn;   // buttons of previous packet

	// reset words as typed constants, so single bits can be picked
	localparam logic [7:0] DCI_RST = `MWK_DCLICK_RESET;
	localparam logic [7:0] CTL_RST = `MWK_CTL_RESET;
	localparam logic [7:0] IRQ_RST = `MWK_IRQ_RESET;

	// address phase taken when selected, ready and nonseq/seq
	wire addr_take = hsel & hready & htrans[1];

	// word aligned, word sized, and inside the 1 KB window
	wire addr_ok = (haddr[1:0] == 2'h0) & (hsize == 3'h2) &
		(haddr[31:10] == 22'h0);

	// write strobes fire in the wait cycle, when hwdata stands
	wire wr_fire = (bus_st == MWK_BUS_WAIT) & pend_wr & pend_ok;
	wire rd_fire = (bus_st == MWK_BUS_WAIT) & ~pend_wr;

	wire hit_dci  = reg_hit(pend_idx, `MWK_IDX_DCLICK);
	wire hit_ctl  = reg_hit(pend_idx, `MWK_IDX_WAKE_CTL);
	wire hit_ists = reg_hit(pend_idx, `MWK_IDX_IRQ_STATUS);
	wire hit_imsk = reg_hit(pend_idx, `MWK_IDX_IRQ_MASK);

	// locked registers drop writes silently; bus still answers okay
	wire wr_dci  = wr_fire & hit_dci & ~lock;
	wire wr_ctl  = wr_fire & hit_ctl & ~lock;
	wire wr_ists = wr_fire & hit_ists;
	wire wr_imsk = wr_fire & hit_imsk;

	// any of the three lesser resets reopens the registers
	wire lock_clr = standby_supply_power_on_reset |
		main_supply_power_on_reset | bus_reset;

	// read data; reserved bits are built in as zero
	wire [7:0] rd_dci  = {spin_off, 1'b0, ivl_code};
	wire [7:0] rd_ctl  = {lock, swap, 1'b0, sel_code,
		2'h0};
	wire [7:0] rd_ists = 8'(wake_click_flag) << `MWK_IRQ_FLAG_BIT;
	wire [7:0] rd_imsk = 8'(flag_mask) << `MWK_IRQ_FLAG_BIT;
	wire [7:0] rd_byte = !pend_ok ? 8'h00 :
		hit_dci  ? rd_dci  :
		hit_ctl  ? rd_ctl  :
		hit_ists ? rd_ists :
		hit_imsk ? rd_imsk : 8'h00;

	// bus phase tracking: every transfer gets exactly one wait state
	// so that read data can come from a flop
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bus_st    <= MWK_BUS_IDLE;
			hreadyout <= 1'b1;
		end else if (ce) begin
			unique case (bus_st)
				MWK_BUS_IDLE: begin
					if (addr_take) begin
						bus_st    <= MWK_BUS_WAIT;
						hreadyout <= 1'b0;
					end
				end
				MWK_BUS_WAIT: begin
					bus_st    <= MWK_BUS_IDLE;
					hreadyout <= 1'b1;
				end
			endcase
		end
	end

	// latch the address phase
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pend_wr  <= 1'b0;
			pend_ok  <= 1'b0;
			pend_idx <= 8'h00;
		end else if (ce && bus_st == MWK_BUS_IDLE && addr_take) begin
			pend_wr  <= hwrite;
			pend_ok  <= addr_ok;
			pend_idx <= haddr[9:2];
		end
	end

	// read data register; unmapped addresses read zero
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hrdata <= 32'h0000_0000;
		end else if (ce && rd_fire) begin
			hrdata <= {24'h00_0000, rd_byte};
		end
	end

	// the slave never errors
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hresp <= 1'b0;
		end else if (ce) begin
			hresp <= 1'b0;
		end
	end

	// interval register; only the battery reset restores it
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			spin_off <= DCI_RST[`MWK_DCLICK_SPIN_BIT];
			ivl_code <= DCI_RST[`MWK_DCLICK_IVL_HI:`MWK_DCLICK_IVL_LO];
		end else if (ce && wr_dci) begin
			spin_off <= hwdata[`MWK_DCLICK_SPIN_BIT];
			ivl_code <= hwdata[`MWK_DCLICK_IVL_HI:`MWK_DCLICK_IVL_LO];
		end
	end

	// control fields other than lock ignore the lesser resets
	// bits 1:0 are not stored, so stray ones there do no harm
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			swap     <= CTL_RST[`MWK_CTL_SWAP_BIT];
			sel_code <= CTL_RST[`MWK_CTL_SEL_HI:`MWK_CTL_SEL_LO];
		end else if (ce && wr_ctl) begin
			swap     <= hwdata[`MWK_CTL_SWAP_BIT];
			sel_code <= hwdata[`MWK_CTL_SEL_HI:`MWK_CTL_SEL_LO];
		end
	end

	// lock: software can only set it, a reset clears it
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lock <= CTL_RST[`MWK_CTL_LOCK_BIT];
		end else if (ce) begin
			if (lock_clr) begin
				lock <= 1'b0;
			end else if (wr_ctl && hwdata[`MWK_CTL_LOCK_BIT]) begin
				lock <= 1'b1;
			end
		end
	end

	// swap control goes straight out of a flop
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			port_swap <= 1'b0;
		end else if (ce) begin
			port_swap <= swap;
		end
	end

	// spin-up delay: reloaded while standby reset is held, so the
	// count runs from its release; skipped when bit 7 is one
	wire spin_load = standby_supply_power_on_reset & ~spin_off;
	wire spin_run;

	mwk_timer #(
		.W (`MWK_SPIN_W)
	) u_spin (
		.core_clk (core_clk),
		.rst      (rst),
		.ce       (ce),
		.load     (spin_load),
		.load_val (`MWK_SPIN_W'(SPINUP_CYCLES)),
		.step     (1'b1),
		.busy     (spin_run)
	);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			spinup_busy <= 1'b0;
		end else if (ce) begin
			spinup_busy <= spin_run | spin_load;
		end
	end

	// button presses: a button down now that was up last packet
	wire [2:0] btn_now = {mouse_middle, mouse_right, mouse_left};
	wire [2:0] press;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_press
			assign press[gi] = mouse_pkt_valid & btn_now[gi] &
				~prev_btn[gi];
		end
	endgenerate

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prev_btn <= 3'h0;
		end else if (ce && mouse_pkt_valid) begin
			prev_btn <= btn_now;
		end
	end

	// single event selection
	mwk_sel_t sel;
	assign sel = mwk_sel_t'(sel_code);

	wire any_press = |press;
	wire moved     = mouse_pkt_valid & mouse_moved;
	wire single_hit =
		(sel == MWK_SEL_ANY_ACT) ? (any_press | moved) :
		(sel == MWK_SEL_LEFT)    ? press[0] :
		(sel == MWK_SEL_RIGHT)   ? press[1] :
		(sel == MWK_SEL_ANY_CLK) ? any_press :
		1'b0;

	// double click: the first press opens a window, a second press
	// of the same button inside it is the event; reserved codes
	// recognise nothing
	wire dbl_press =
		(sel == MWK_SEL_DBL_LEFT) ? press[0] :
		(sel == MWK_SEL_DBL_RGHT) ? press[1] :
		1'b0;
	wire win_open;
	wire dbl_hit  = dbl_press & win_open;
	wire win_load = dbl_press;

	// a hit closes the window so a third click starts afresh
	wire [`MWK_WIN_W-1:0] win_len = dbl_hit ? `MWK_WIN_W'(0) :
		`MWK_WIN_W'(ivl_code) + `MWK_WIN_W'(1);
	wire unit_tick;

	// tick phase restarts on each load, so the window is exact
	mwk_tick #(
		.W      (`MWK_TICK_W),
		.PERIOD (DCLICK_UNIT_CYCLES)
	) u_tick (
		.core_clk (core_clk),
		.rst      (rst),
		.ce       (ce),
		.restart  (win_load),
		.tick     (unit_tick)
	);

	mwk_timer #(
		.W (`MWK_WIN_W)
	) u_win (
		.core_clk (core_clk),
		.rst      (rst),
		.ce       (ce),
		.load     (win_load),
		.load_val (win_len),
		.step     (unit_tick),
		.busy     (win_open)
	);

	// a recognised event in any mode
	wire event_hit = single_hit | dbl_hit;

	// wake pulse, one cycle per recognised event
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pme_wake <= 1'b0;
		end else if (ce) begin
			pme_wake <= event_hit;
		end
	end

	// sticky flag: a new event wins over a clearing write
	wire flag_clr  = wr_ists & hwdata[`MWK_IRQ_FLAG_BIT];
	wire next_flag = event_hit | (wake_click_flag & ~flag_clr);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wake_click_flag <= IRQ_RST[`MWK_IRQ_FLAG_BIT];
		end else if (ce) begin
			wake_click_flag <= next_flag;
		end
	end

	// interrupt mask
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			flag_mask <= IRQ_RST[`MWK_IRQ_FLAG_BIT];
		end else if (ce && wr_imsk) begin
			flag_mask <= hwdata[`MWK_IRQ_FLAG_BIT];
		end
	end

	// level interrupt, changes in the same cycle as the flag
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= next_flag & flag_mask;
		end
	end
endmodule // mwk_mouse_wake
`default_nettype wire

// [tb/mwk_asserts.sv]
// concurrent checks on the mouse wake control ports
`default_nettype none
module mwk_asserts #(
	parameter int unsigned SPINUP_CYCLES = 20
) (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        rst,
	// bus side
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic [31:0] hwdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	// mouse, resets and results
	input wire logic        standby_supply_power_on_reset,
	input wire logic        mouse_pkt_valid,
	input wire logic        port_swap,
	input wire logic        pme_wake,
	input wire logic        irq,
	input wire logic        spinup_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SPIN_LO = SPINUP_CYCLES - 2; // slack for registering
	localparam int SPIN_HI = SPINUP_CYCLES + 2;
	logic [31:0] spin_cnt; // busy cycles since the standby reset let go

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// count how long the spin-up flag stays up after release
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst || standby_supply_power_on_reset)
			spin_cnt <= 32'h0;
		else if (spinup_busy)
			spin_cnt <= spin_cnt + 32'h1;
	end

	a_resp_okay: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	a_one_wait: assert property ((hsel && htrans[1] && hreadyout) |=>
		!hreadyout ##1 hreadyout) else $error("wait state not one cycle");
	a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_wake_cause: assert property (pme_wake |-> $past(mouse_pkt_valid))
		else $error("wake without a packet");
	// the swap flop trails the register write by one more cycle
	a_swap_write: assert property ($changed(port_swap) |->
		$past(!hreadyout, 2) && $past(hwdata[6], 2) == port_swap)
		else $error("swap changed without a write");
	a_irq_rise: assert property ($rose(irq) |-> pme_wake ||
		$past(pme_wake) || $past(!hreadyout) || $past(!hreadyout, 2))
		else $error("interrupt rose without cause");
	a_irq_fall: assert property ($fell(irq) |->
		$past(!hreadyout) || $past(!hreadyout, 2))
		else $error("interrupt fell without a write");
	a_spin_start: assert property ($rose(spinup_busy) |->
		$past(standby_supply_power_on_reset))
		else $error("spin-up without standby reset");
	a_spin_len: assert property ($fell(spinup_busy) |->
		spin_cnt >= SPIN_LO && spin_cnt <= SPIN_HI)
		else $error("spin-up delay length wrong");
endmodule // mwk_asserts
`default_nettype wire

// [tb/mwk_mouse_model.sv]
// pointing device model: sends one decoded packet per request
`default_nettype none
module mwk_mouse_model (
	// clock and request
	input wire logic       core_clk,
	input wire logic       send,
	input wire logic [3:0] pkt, // move, middle, right, left
	// decoded packet lines
	output logic           mouse_pkt_valid,
	output logic           mouse_left,
	output logic           mouse_right,
	output logic           mouse_middle,
	output logic           mouse_moved
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] last = 4'h0; // what the lines showed last cycle

	// between packets the lines toggle, so stale data never looks valid
	always @(posedge core_clk) begin
		mouse_pkt_valid <= send;
		last <= send ? pkt : ~last;
	end
	assign {mouse_moved, mouse_middle, mouse_right, mouse_left} = last;
endmodule // mwk_mouse_model
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the mouse wake control block
`default_nettype none
`include "mwk_consts.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SPIN = 20; // short spin-up for simulation
	localparam int UNIT = 4;  // short interval step
	logic        core_clk, rst, hsel, hwrite, send, hresp, hreadyout;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic [3:0]  pkt, b;
	logic [7:0]  c;
	logic        standby_supply_power_on_reset, main_supply_power_on_reset;
	logic        bus_reset, mouse_pkt_valid, mouse_left, mouse_right;
	logic        mouse_middle, mouse_moved, port_swap, pme_wake, irq;
	logic        spinup_busy;
	logic [7:0]  exp_q[$]; // expected read bytes, oldest first
	logic        rd_pend = 1'b0;
	int          failures = 0, check_count = 0, wakes = 0, n, w;
	int          exp_w[8] = '{4, 1, 1, 3, 0, 0, 0, 0};

	mwk_mouse_wake #(
		.SPINUP_CYCLES      (SPIN),
		.DCLICK_UNIT_CYCLES (UNIT)
	) dut (
		.*,
		.ce     (1'b1),
		.hsize  (3'h2),
		.hready (hreadyout)
	);
	mwk_mouse_model mouse (.*);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic chk(string what, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask

	// watch outputs: count wakes, match read data to the oldest note
	always @(posedge core_clk) begin
		if (pme_wake === 1'b1)
			wakes++;
		if (rd_pend && hreadyout === 1'b1) begin
			rd_pend = 1'b0;
			chk("read data", {24'h0, exp_q.pop_front()}, hrdata);
		end
		if (hsel && htrans[1] && hreadyout === 1'b1)
			rd_pend = !hwrite;
	end

	// one single word transfer, held until ready is seen high
	task automatic bus(logic wr, logic [7:0] idx, logic [7:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {22'h0, idx, 2'h0};
		@(posedge core_clk iff hreadyout === 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge core_clk iff hreadyout === 1'b1);
	endtask
	task automatic wr(logic [7:0] idx, logic [7:0] d);
		bus(1'b1, idx, d);
	endtask
	task automatic rd(logic [7:0] idx, logic [7:0] e);
		exp_q.push_back(e);
		bus(1'b0, idx, 8'h00);
	endtask
	task automatic idle(int k);
		repeat (k) @(posedge core_clk);
	endtask
	task automatic send_pkt(logic [3:0] p);
		send <= 1'b1;
		pkt <= p;
		idle(1);
		send <= 1'b0;
		idle(1);
	endtask
	task automatic clicks(logic [3:0] p); // press, then release
		send_pkt(p);
		send_pkt(4'h0);
	endtask
	task automatic rst_pulse(logic [2:0] r); // standby, main, bus
		{standby_supply_power_on_reset, main_supply_power_on_reset,
			bus_reset} <= r;
		idle(2);
		{standby_supply_power_on_reset, main_supply_power_on_reset,
			bus_reset} <= 3'h0;
		idle(2);
	endtask

	task automatic test_done();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// watchdog: the whole sequence needs well under 20000 cycles
	initial begin
		#200000;
		failures++;
		test_done();
	end

	initial begin
		{rst, hsel, hwrite, send, pkt, haddr, hwdata, htrans} = '0;
		rst = 1'b1;
		{standby_supply_power_on_reset, main_supply_power_on_reset,
			bus_reset} = 3'h0;
		void'($urandom(32'h70E8));
		idle(20);
		rst <= 1'b0;
		idle(1);
		rd(`MWK_IDX_DCLICK, `MWK_DCLICK_RESET);
		rd(`MWK_IDX_WAKE_CTL, `MWK_CTL_RESET);
		rd(`MWK_IDX_IRQ_STATUS, 8'h00);
		rd(`MWK_IDX_IRQ_MASK, 8'h00);
		wr(8'h20, 8'($urandom));
		rd(8'h20, 8'h00);
		wr(`MWK_IDX_DCLICK, 8'hFF);
		rd(`MWK_IDX_DCLICK, 8'hBF);
		wr(`MWK_IDX_WAKE_CTL, 8'h7C);
		rd(`MWK_IDX_WAKE_CTL, 8'h5C);
		chk("port_swap", 32'h1, port_swap);
		$display("test register fields done");
		wr(`MWK_IDX_IRQ_MASK, 8'h10);
		wr(`MWK_IDX_DCLICK, 8'h05);
		for (int s = 0; s < 8; s++) begin
			wr(`MWK_IDX_WAKE_CTL, 8'(s << 2));
			n = wakes;
			clicks(4'h1);
			clicks(4'h2);
			clicks(4'h4);
			send_pkt(4'h8);
			idle(40);
			chk("wakes", 32'(exp_w[s]), 32'(wakes - n));
		end
		chk("irq", 32'h1, irq);
		rd(`MWK_IDX_IRQ_STATUS, 8'h10);
		wr(`MWK_IDX_IRQ_STATUS, 8'h10);
		rd(`MWK_IDX_IRQ_STATUS, 8'h00);
		chk("irq", 32'h0, irq);
		$display("test event codes done");
		c = 8'($urandom % 4 + 2);
		w = (c + 1) * UNIT; // double click window in cycles
		wr(`MWK_IDX_DCLICK, c);
		for (int s = 5; s < 7; s++) begin
			wr(`MWK_IDX_WAKE_CTL, 8'(s << 2));
			b = (s == 5) ? 4'h1 : 4'h2;
			n = wakes;
			clicks(b);
			clicks(4'h4);
			clicks(b);
			idle(w + 10);
			clicks(b);
			idle(w - 4); // second press exactly w cycles on: inside
			clicks(b);
			idle(w + 10);
			clicks(b);
			idle(w - 3); // second press w + 1 cycles on: too late
			clicks(b);
			idle(w + 10);
			chk("double clicks", 32'h2, 32'(wakes - n));
		end
		$display("test double click done");
		wr(`MWK_IDX_IRQ_MASK, 8'h00);
		wr(`MWK_IDX_WAKE_CTL, 8'h0C);
		clicks(4'h1);
		idle(4);
		chk("masked irq", 32'h0, irq);
		rd(`MWK_IDX_IRQ_STATUS, 8'h10);
		wr(`MWK_IDX_IRQ_MASK, 8'h10);
		idle(3);
		chk("unmasked irq", 32'h1, irq);
		wr(`MWK_IDX_IRQ_STATUS, 8'h10);
		$display("test interrupt done");
		for (int k = 0; k < 3; k++) begin
			wr(`MWK_IDX_WAKE_CTL, 8'hCC);
			wr(`MWK_IDX_WAKE_CTL, 8'h00);
			wr(`MWK_IDX_DCLICK, 8'h3F);
			rd(`MWK_IDX_WAKE_CTL, 8'hCC);
			rd(`MWK_IDX_DCLICK, c);
			rst_pulse(3'h4 >> k);
			rd(`MWK_IDX_WAKE_CTL, 8'h4C);
			rd(`MWK_IDX_DCLICK, c);
		end
		$display("test lock done");
		rst_pulse(3'h4);
		chk("spin-up busy", 32'h1, spinup_busy);
		idle(SPIN + 5);
		chk("spin-up over", 32'h0, spinup_busy);
		wr(`MWK_IDX_DCLICK, 8'h80 | c);
		rst_pulse(3'h4);
		chk("no spin-up", 32'h0, spinup_busy);
		$display("test spin-up done");
		test_done();
	end
endmodule // tb_top

bind mwk_mouse_wake mwk_asserts #(.SPINUP_CYCLES(SPINUP_CYCLES)) u_chk (.*);
`default_nettype wire
